// ==== verification/ods_host_model.sv ====
// Host side of the serial link: frames words onto the shifter.
// Assumes the bench resolves the shared serial output line.
`timescale 1ns/1ps
`default_nettype none
module ods_host_model (
  output logic sclk, // Link clock, still between frames
  output logic sync_n, // Frame select
  output logic serial_in, // Data to the block
  input wire logic line // Resolved serial output
);
  logic [23:0] rx;
  // Idle link
  initial begin
    sclk = 1'b0;
    sync_n = 1'b1;
    serial_in = 1'b0;
    rx = 24'h0;
  end
  // Send n bits MSB first, capture the line at each fall
  task automatic xfer(input logic [47:0] w, input int n);
    #13 sync_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      serial_in = w[i];
      #16 sclk = 1'b1;
      #32 rx = {rx[22:0], line};
      sclk = 1'b0;
      #16;
    end
    sync_n = 1'b1;
    serial_in = ~serial_in;
  endtask
endmodule // ods_host_model
`default_nettype wire

// ==== verification/ods_serial_ctrl_monitor.sv ====
// Checker bound onto the serial control block, top ports only.
// Assumes the system clock domain samples all watched outputs.
`timescale 1ns/1ps
`default_nettype none
module ods_serial_ctrl_monitor (
  input wire logic CLOCK, // System clock
  input wire logic RESET, // Sync reset
  input wire logic SYNC_N, // Frame select
  input wire logic SERIAL_OUT_OE_N, // Drive enable
  input wire logic SERIAL_OUT_KEEP, // Keeper on
  input wire logic CHAIN_ENABLE, // Chain mode
  input wire ods_pkg::ods_code_t POWER_MODE, // Power bits
  input wire ods_pkg::ods_chmask_t OUT_PULLDOWN, // 1k load
  input wire ods_pkg::ods_chmask_t OUT_HIZ, // Open output
  input wire logic FRAME_DONE // Frame pulse
);
  import ods_pkg::*;
  // Every check runs on the system clock
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RESET);
  chk_keeper_idle: assert property (SERIAL_OUT_KEEP == SYNC_N)
    else $error("keeper differs from frame select");
  chk_idle_no_drive: assert property (SYNC_N |-> SERIAL_OUT_OE_N)
    else $error("strong drive outside a frame");
  chk_done_single: assert property (FRAME_DONE |=> !FRAME_DONE)
    else $error("frame pulse longer than one cycle");
  chk_pulldown_dec: assert property ($stable(POWER_MODE) |->
    OUT_PULLDOWN[0] == (POWER_MODE[1:0] == 2'h1))
    else $error("channel 0 load decode wrong");
  chk_hiz_dec: assert property ($stable(POWER_MODE) |->
    OUT_HIZ[7] == (POWER_MODE[15:14] == 2'h3))
    else $error("channel 7 open decode wrong");
  chk_power_frame: assert property ((!SYNC_N)[*6] |->
    $stable(POWER_MODE))
    else $error("power bits moved inside a frame");
  chk_chain_frame: assert property ((!SYNC_N)[*6] |->
    $stable(CHAIN_ENABLE))
    else $error("chain mode moved inside a frame");
  chk_update_done: assert property ($changed(POWER_MODE) ||
    $changed(CHAIN_ENABLE) |-> ##[0:2] FRAME_DONE)
    else $error("mode update without frame pulse");
endmodule // ods_serial_ctrl_monitor
bind ods_serial_ctrl ods_serial_ctrl_monitor u_mon (
  .CLOCK(CLOCK),
  .RESET(RESET),
  .SYNC_N(SYNC_N),
  .SERIAL_OUT_OE_N(SERIAL_OUT_OE_N),
  .SERIAL_OUT_KEEP(SERIAL_OUT_KEEP),
  .CHAIN_ENABLE(CHAIN_ENABLE),
  .POWER_MODE(POWER_MODE),
  .OUT_PULLDOWN(OUT_PULLDOWN),
  .OUT_HIZ(OUT_HIZ),
  .FRAME_DONE(FRAME_DONE)
);
`default_nettype wire

// ==== verification/tb_top.sv ====
// Self-checking bench for the serial control block.
// Assumes the host model and the bound checker are compiled too.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import ods_pkg::*;
  logic clk, rst, load_n, so, oe_n, keep, chain, done;
  wire sclk, sync_n, sin, line;
  logic [127:0] dac;
  ods_code_t pm;
  ods_chmask_t pd, hz;
  int err_count, tests_run;
  // Clock, and the pad: keeper holds, undriven line flips
  always #20 clk = ~clk;
  assign line = (!oe_n || keep) ? so : ~so;
  ods_host_model host (
    .sclk(sclk),
    .sync_n(sync_n),
    .serial_in(sin),
    .line(line)
  );
  ods_serial_ctrl DUT (
    .CLOCK(clk),
    .RESET(rst),
    .CLK_EN(1'b1),
    .SCLK(sclk),
    .SYNC_N(sync_n),
    .SERIAL_IN(sin),
    .LOAD_PIN_N(load_n),
    .SERIAL_OUT(so),
    .SERIAL_OUT_OE_N(oe_n),
    .SERIAL_OUT_KEEP(keep),
    .CHAIN_ENABLE(chain),
    .DAC_CODES(dac),
    .POWER_MODE(pm),
    .OUT_PULLDOWN(pd),
    .OUT_HIZ(hz),
    .FRAME_DONE(done)
  );
  function automatic logic [15:0] ch(input int k);
    return dac[16*k +: 16];
  endfunction
  task automatic chk(input string what, input logic [31:0] exp, got);
    tests_run++;
    if (exp !== got) begin
      err_count++;
      $display("[ERR] %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // One frame, then a bounded wait for its execution
  task automatic frame(input logic [47:0] w, input int n = 24);
    int i;
    host.xfer(w, n);
    for (i = 0; i < 30 && done !== 1'b1; i++) @(negedge clk);
    if (i == 30) begin
      err_count++;
      $display("[ERR] frame done exp 1 got %b", done);
      stop_test();
    end
    repeat (4) @(negedge clk);
  endtask
  task automatic s_write;
    chk("chain rst", 0, chain);
    frame(24'h37abcd);
    chk("ch7", 16'habcd, ch(7));
    frame(24'h38aaaa);
    chk("addr8", 0, |dac[111:0]);
  endtask
  task automatic s_load;
    frame(24'h115555);
    frame(24'h121234);
    chk("ch2 held", 0, ch(2));
    frame(24'h500002);
    load_n = 1'b0;
    repeat (6) @(negedge clk);
    chk("ch2 load", 16'h1234, ch(2));
    chk("ch1 masked", 0, ch(1));
    load_n = 1'b1;
    frame(24'h200002);
    chk("ch1 copy", 16'h5555, ch(1));
    frame(24'h500010);
    load_n = 1'b0;
    frame(24'h134444);
    chk("ch3 direct", 16'h4444, ch(3));
    frame(24'h146666);
    chk("ch4 tied low", 16'h6666, ch(4));
    load_n = 1'b1;
  endtask
  task automatic s_power;
    frame(24'h40c001);
    chk("power", 16'hc001, pm);
    chk("pulldown", 8'h01, pd);
    chk("hiz", 8'h80, hz);
    frame(24'h37beef);
    chk("ch7 down", 16'hbeef, ch(7));
    frame(24'hc0ffff);
    chk("unknown", 16'hc001, pm);
  endtask
  task automatic s_readback;
    frame(24'h920000);
    frame(24'h000000);
    chk("readback", 16'h1234, host.rx[15:0]);
  endtask
  task automatic s_chain;
    frame(24'h800001);
    chk("chain on", 1, chain);
    frame({24'h123456, 24'h30beef}, 48);
    chk("ripple", 24'h123456, host.rx);
    chk("ch0", 16'hbeef, ch(0));
    frame(48'hf350077, 28);
    chk("odd count", 16'h0077, ch(5));
    frame(24'h800000);
    chk("chain off", 0, chain);
  endtask
  // Reset in mid-run returns chain and power to defaults
  task automatic s_reset;
    frame(24'h800001);
    frame(24'h40000c);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    chk("chain reset", 0, chain);
    chk("power reset", 0, pm);
    frame(24'h400003);
    chk("power after", 16'h0003, pm);
  endtask
  // Reset, then the scenarios in turn
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    load_n = 1'b1;
    err_count = 0;
    tests_run = 0;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    s_write();
    s_load();
    s_power();
    s_readback();
    s_chain();
    s_reset();
    stop_test();
  end
endmodule // tb_top
`default_nettype wire

// ==== verilog/ods_defines.svh ====
// Constants of the octal DAC serial control block: frame layout,
// command codes and reset values.
// Assumes inclusion by bare name from the package and the design.
`ifndef ODS_DEFINES_SVH
`define ODS_DEFINES_SVH

// Frame layout, most significant bit first
`define ODS_FRAME_BITS 24
`define ODS_CMD_HI 23
`define ODS_CMD_LO 20
`define ODS_ADDR_HI 19
`define ODS_ADDR_LO 16
`define ODS_DATA_HI 15
`define ODS_DATA_LO 0
`define ODS_CHANNELS 8

// Command codes
`define ODS_CMD_NOP 4'h0
`define ODS_CMD_WR_INPUT 4'h1
`define ODS_CMD_COPY_SEL 4'h2
`define ODS_CMD_WR_BOTH 4'h3
`define ODS_CMD_POWER 4'h4
`define ODS_CMD_MASK 4'h5
`define ODS_CMD_CHAIN 4'h8
`define ODS_CMD_READBACK 4'h9
`define ODS_CMD_NOP_CHAIN 4'hf

// Reset values
`define ODS_CHAIN_RST 1'h0
`define ODS_MASK_RST 8'h00
`define ODS_POWER_RST 16'h0000
`define ODS_CODE_RST 16'h0000

// Readback word: leading filler bits, then the register value
`define ODS_RB_FILL 8'h00
// Bit index after which a frame's synchronised flags are trusted
`define ODS_SYNC_SETTLE 5'h02
`define ODS_CNT_MAX 5'h1f
// Last readback bit index, and count at which the readback word ends
`define ODS_RB_LAST 5'h17
`define ODS_FRAME_CNT 5'h18

`endif

// ==== verilog/ods_pkg.sv ====
// Types shared by the octal DAC serial control block.
// Assumes ods_defines.svh is on the include path.
`default_nettype none
package ods_pkg;
  `include "ods_defines.svh"
  typedef logic [15:0] ods_code_t;
  typedef logic [3:0] ods_cmd_t;
  typedef logic [`ODS_FRAME_BITS-1:0] ods_frame_t;
  typedef logic [`ODS_CHANNELS-1:0] ods_chmask_t;
  typedef logic [4:0] ods_count_t;
endpackage
`default_nettype wire

// ==== verilog/ods_serial_ctrl.sv ====
// Serial command logic of an eight-channel DAC: frame shifter on the
// serial clock, command decode and register banks on the system clock.
// Assumes a host framing 24-bit words with an active-low frame select,
// and a pad that resolves serial_out from drive enable and keeper.
`timescale 1ns/1ps
`default_nettype none
`include "ods_defines.svh"

module ods_serial_ctrl (
  input wire logic CLOCK, // System clock
  input wire logic RESET, // Synchronous reset, active high
  input wire logic CLK_EN, // System clock enable
  input wire logic SCLK, // Serial link clock
  input wire logic SYNC_N, // Frame select, active low
  input wire logic SERIAL_IN, // Serial data in
  input wire logic LOAD_PIN_N, // Load pin, active low
  output logic SERIAL_OUT, // Serial data out level
  output logic SERIAL_OUT_OE_N, // Strong drive enable, active low
  output logic SERIAL_OUT_KEEP, // Weak keeper holds SERIAL_OUT
  output logic CHAIN_ENABLE, // Chain mode selected
  output logic [127:0] DAC_CODES, // DAC registers, channel 0 lowest
  output ods_pkg::ods_code_t POWER_MODE, // Two power bits per channel
  output ods_pkg::ods_chmask_t OUT_PULLDOWN, // Channel on 1k load
  output ods_pkg::ods_chmask_t OUT_HIZ, // Channel output open
  output logic FRAME_DONE // Pulse when a frame is executed
);
  import ods_pkg::*;

  // Address decode shared by the write and readback commands
  function automatic logic ch_valid(input logic [3:0] addr);
    ch_valid = (addr[3] == 1'b0);
  endfunction

  function automatic logic [2:0] ch_index(input logic [3:0] addr);
    ch_index = addr[2:0];
  endfunction

  // Readback command aimed at a real channel
  function automatic logic rb_hit(input ods_cmd_t c,
    input logic [3:0] a);
    rb_hit = (c == `ODS_CMD_READBACK) && ch_valid(a);
  endfunction

  // Two power bits of one channel, high bit first
  function automatic logic [1:0] pm_field(input ods_code_t p,
    input int k);
    pm_field = p[2*k +: 2];
  endfunction

  // Link domain: everything below runs on the serial clock
  // Shifter and bit counter
  ods_frame_t shift_q;
  ods_count_t cnt_q;
  // Synchronised flags from the system side
  logic link_rst_q;
  logic chain_s1_q;
  logic chain_s2_q;
  logic arm_s1_q;
  logic arm_s2_q;
  // Output path
  logic sdo_q;
  logic sdo_d;
  logic chain_q;
  logic rb_arm_q;
  ods_code_t rb_val_q;
  logic [`ODS_FRAME_BITS-1:0] rb_word;
  logic settled;
  logic drive_en;

  // Input shifter: every falling edge inside a frame, no count limit
  // Long frames keep only the newest bits; older ones fall out the
  // top and feed the chain output
  always_ff @(negedge SCLK) begin
    if (!SYNC_N) begin
      shift_q <= {shift_q[`ODS_FRAME_BITS-2:0], SERIAL_IN};
    end
  end

  // Bit counter, cleared by the idle frame select itself
  // Saturates so a long chain frame never wraps back below the
  // settle point and briefly drops the pad drive
  always_ff @(negedge SCLK or posedge SYNC_N) begin
    if (SYNC_N) begin
      cnt_q <= 5'h00;
    end else if (cnt_q != `ODS_CNT_MAX) begin
      cnt_q <= cnt_q + 5'h01;
    end
  end

  // Chain flag from the system side, two stages
  always_ff @(negedge SCLK or posedge link_rst_q) begin
    if (link_rst_q) begin
      chain_s1_q <= 1'b0;
      chain_s2_q <= 1'b0;
    end else begin
      chain_s1_q <= chain_q;
      chain_s2_q <= chain_s1_q;
    end
  end

  // Readback arm from the system side, two stages
  always_ff @(negedge SCLK or posedge link_rst_q) begin
    if (link_rst_q) begin
      arm_s1_q <= 1'b0;
      arm_s2_q <= 1'b0;
    end else begin
      arm_s1_q <= rb_arm_q;
      arm_s2_q <= arm_s1_q;
    end
  end

  // Flags trusted only once both stages saw this frame's level
  assign settled = (cnt_q >= `ODS_SYNC_SETTLE);
  assign rb_word = {`ODS_RB_FILL, rb_val_q};

  // Next output bit: readback word or chain overflow
  always_comb begin
    sdo_d = sdo_q;
    if (!SYNC_N && cnt_q != 5'h00) begin
      if (arm_s2_q && settled) begin
        if (cnt_q < `ODS_FRAME_CNT) begin
          sdo_d = rb_word[`ODS_RB_LAST - cnt_q];
        end else begin
          sdo_d = 1'b0;
        end
      end else begin
        sdo_d = shift_q[`ODS_FRAME_BITS-1];
      end
    end
  end

  // Output flop, rising serial edges only
  always_ff @(posedge SCLK or posedge link_rst_q) begin
    if (link_rst_q) begin
      sdo_q <= 1'b0;
    end else begin
      sdo_q <= sdo_d;
    end
  end

  // Strong drive only inside a frame in chain or readback mode.
  // The first two falls are skipped so the synced flags show the
  // latest latch before the pad turns on; outside a frame the pad
  // keeper holds the last bit so a shared line can be overdriven.
  assign drive_en = !SYNC_N && settled && (chain_s2_q || arm_s2_q);
  assign SERIAL_OUT = sdo_q;
  assign SERIAL_OUT_OE_N = !drive_en;
  assign SERIAL_OUT_KEEP = SYNC_N;

  // System domain. The shift register is read here only while
  // frame select is high, so the link side is quiet when a word is
  // decoded; the readback value is written only at that latch and
  // read by the link side in the following frame. Both words stay
  // static across the crossing, so only single-bit flags need the
  // two-stage synchronisers.
  // Synchroniser stages
  logic sy1_q;
  logic sy2_q;
  logic sy3_q;
  logic ld1_q;
  logic ld2_q;
  logic ld3_q;
  // Strobes and decoded frame fields
  logic frame_end;
  logic load_fall;
  logic load_low;
  ods_frame_t word;
  ods_cmd_t cmd;
  logic [3:0] addr;
  ods_code_t data;
  logic [2:0] idx;
  logic hit;
  // Register banks and mode registers
  ods_code_t in_q [`ODS_CHANNELS];
  ods_code_t dac_q [`ODS_CHANNELS];
  ods_code_t power_q;
  ods_chmask_t mask_q;
  logic done_q;

  // Link reset taken from the system reset, released on CLOCK
  always_ff @(posedge CLOCK) begin
    link_rst_q <= RESET;
  end

  // Frame select: two stages, then a third for edge detect
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      sy1_q <= 1'b1;
      sy2_q <= 1'b1;
      sy3_q <= 1'b1;
    end else if (CLK_EN) begin
      sy1_q <= SYNC_N;
      sy2_q <= sy1_q;
      sy3_q <= sy2_q;
    end
  end

  // Load pin: idle high after reset, so no false fall
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      ld1_q <= 1'b1;
      ld2_q <= 1'b1;
      ld3_q <= 1'b1;
    end else if (CLK_EN) begin
      ld1_q <= LOAD_PIN_N;
      ld2_q <= ld1_q;
      ld3_q <= ld2_q;
    end
  end

  // Latch strobe, pin fall and synced pin level
  assign frame_end = CLK_EN && sy2_q && !sy3_q;
  assign load_fall = CLK_EN && ld3_q && !ld2_q;
  assign load_low = !ld2_q;

  // Word is stable: shifting stopped when frame select rose
  assign word = shift_q;
  assign cmd = word[`ODS_CMD_HI:`ODS_CMD_LO];
  assign addr = word[`ODS_ADDR_HI:`ODS_ADDR_LO];
  assign data = word[`ODS_DATA_HI:`ODS_DATA_LO];
  assign idx = ch_index(addr);
  assign hit = ch_valid(addr);

  // Input registers: written by 0001 and 0011 only
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      for (int i = 0; i < `ODS_CHANNELS; i++) begin
        in_q[i] <= `ODS_CODE_RST;
      end
    end else if (frame_end && hit) begin
      if (cmd == `ODS_CMD_WR_INPUT || cmd == `ODS_CMD_WR_BOTH) begin
        in_q[idx] <= data;
      end
    end
  end

  // DAC registers. A pin fall and a frame command may land in one
  // cycle; the frame command is applied last, so it wins. A pin
  // held low makes 0001 write through whatever the mask says,
  // since the mask only blocks pin transitions.
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      for (int i = 0; i < `ODS_CHANNELS; i++) begin
        dac_q[i] <= `ODS_CODE_RST;
      end
    end else begin
      for (int i = 0; i < `ODS_CHANNELS; i++) begin
        if (load_fall && !mask_q[i]) begin
          dac_q[i] <= in_q[i];
        end
        if (frame_end && cmd == `ODS_CMD_COPY_SEL && data[i]) begin
          dac_q[i] <= in_q[i];
        end
      end
      if (frame_end && hit) begin
        unique case (cmd)
          `ODS_CMD_WR_INPUT: begin
            if (load_low) begin
              dac_q[idx] <= data;
            end
          end
          `ODS_CMD_WR_BOTH: begin
            dac_q[idx] <= data;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Power bits: 0100 loads every channel field
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      power_q <= `ODS_POWER_RST;
    end else if (frame_end && cmd == `ODS_CMD_POWER) begin
      power_q <= data;
    end
  end

  // Load-pin mask: 0101, address field ignored
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      mask_q <= `ODS_MASK_RST;
    end else if (frame_end && cmd == `ODS_CMD_MASK) begin
      mask_q <= data[7:0];
    end
  end

  // Chain enable: 1000, lowest data bit
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      chain_q <= `ODS_CHAIN_RST;
    end else if (frame_end && cmd == `ODS_CMD_CHAIN) begin
      chain_q <= data[0];
    end
  end

  // Readback arm: set by 1001, cleared by the frame that follows
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      rb_arm_q <= 1'b0;
    end else if (frame_end) begin
      rb_arm_q <= rb_hit(cmd, addr);
    end
  end

  // Readback value: input register snapshot at the latch
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      rb_val_q <= `ODS_CODE_RST;
    end else if (frame_end && rb_hit(cmd, addr)) begin
      rb_val_q <= in_q[idx];
    end
  end

  // Frame executed strobe
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      done_q <= 1'b0;
    end else if (CLK_EN) begin
      done_q <= frame_end;
    end
  end

  // Output views of the registers and power decode
  always_comb begin
    for (int i = 0; i < `ODS_CHANNELS; i++) begin
      DAC_CODES[16*i +: 16] = dac_q[i];
      OUT_PULLDOWN[i] = (pm_field(power_q, i) == 2'h1);
      OUT_HIZ[i] = (pm_field(power_q, i) == 2'h3);
    end
  end

  assign POWER_MODE = power_q;
  assign CHAIN_ENABLE = chain_q;
  assign FRAME_DONE = done_q;
endmodule // ods_serial_ctrl
`default_nettype wire
